/* core/spcs_pkg.sv */
// constants shared by the port command and status register block
package spcs_pkg;
  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SPCS_OFF_PORT_CMD = 8'h18; // port_command_status offset
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int SPCS_B_FRE = 4;   // fis_receive_enable
  localparam int SPCS_B_MPSS = 13; // switch state, lower field
  localparam int SPCS_B_FR = 14;   // fis_receive_running
  localparam int SPCS_B_CR = 15;   // command_list_running
  localparam int SPCS_B_CPS = 16;  // cold_presence_state
  localparam int SPCS_B_PMA = 17;  // port_multiplier_attached
  localparam int SPCS_B_HOT_PLUG_CAPABLE = 18; // hot_plug_capable
  localparam int SPCS_B_MECH_SWITCH_SUPPORTED = 19; // mech_switch_supported
  localparam int SPCS_B_CPD = 20;  // cold_presence_supported
  localparam int SPCS_B_ESP = 21;  // external_signal_only_port
  localparam int SPCS_B_PKT = 24;  // packet-command device
  localparam int SPCS_B_LED_ON_PACKET_DEVICE_ENABLE = 25; // led_on_packet_device_enable
  localparam int SPCS_B_AGGRESSIVE_LINK_PM_ENABLE = 26; // aggressive_link_pm_enable
  localparam int SPCS_B_ASP = 27;  // slumber_not_partial_select
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic SPCS_RST_HOT_PLUG_CAPABLE = 1'b1;
  localparam logic SPCS_RST_OTHER = 1'b0;
  // ---------------------------------------------------------------------------
  // link power request codes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {SPCS_LP_ACTIVE, SPCS_LP_PARTIAL, SPCS_LP_SLUMBER} spcs_lp_e;
endpackage

/* core/spcs_led.sv */
// activity led decision for the port
`timescale 1ns/1ps
module spcs_led (
  input wire logic cmd_active,
  input wire logic packet_dev,
  input wire logic led_on_packet,
  output logic led_on
);
  // ---------------------------------------------------------------------------
  // led gating
  // ---------------------------------------------------------------------------
  // packet devices light the led only when explicitly allowed
  always_comb begin
    led_on = cmd_active & (led_on_packet | ~packet_dev);
  end
endmodule

/* core/spcs_top.sv */
// upper fields of the port command and status register, led and link power
`timescale 1ns/1ps
module spcs_top
  import spcs_pkg::*;
#(
  parameter int ADDR_W = 8 // register window address width
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [31:0] WDATA,
  output logic [31:0] RDATA,
  input wire logic CAP_MULTIPLIER_SUPPORT,
  input wire logic CAP_AGGRESSIVE_LPM_SUPPORT,
  input wire logic PLAT_HOT_PLUG_CAPABLE,
  input wire logic PLAT_MECH_SWITCH_SUPPORTED,
  input wire logic PLAT_COLD_PRESENCE_SUPPORTED,
  input wire logic PLAT_EXTERNAL_SIGNAL_ONLY,
  input wire logic COLD_PRESENCE_DETECT,
  input wire logic MECH_SWITCH_OPEN,
  input wire logic FIS_RX_BUSY,
  input wire logic FIS_RX_PENDING,
  input wire logic FIS_RX_FIRST_D2H,
  input wire logic CMD_LIST_BUSY,
  input wire logic CMD_ISSUED_ANY,
  input wire logic ACTIVE_QUEUE_ANY,
  input wire logic LINK_IDLE,
  output logic FIS_RX_POST,
  output logic ACT_LED,
  output logic [1:0] LINK_PM_REQ
);
  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  logic fre_reg, fre_next;             // fis_receive_enable
  logic fr_reg, fr_next;               // fis_receive_running
  logic cr_reg, cr_next;               // command_list_running
  logic cps_reg, cps_next;             // cold_presence_state
  logic pma_reg, pma_next;             // port_multiplier_attached
  logic hot_plug_capable_reg, hot_plug_capable_next;           // hot_plug_capable
  logic mech_switch_supported_reg, mech_switch_supported_next;           // mech_switch_supported
  logic cpd_reg, cpd_next;             // cold_presence_supported
  logic esp_reg, esp_next;             // external_signal_only_port
  logic pkt_reg, pkt_next;             // packet-command device
  logic led_on_packet_device_enable_reg, led_on_packet_device_enable_next;           // led_on_packet_device_enable
  logic aggressive_link_pm_enable_reg, aggressive_link_pm_enable_next;           // aggressive_link_pm_enable
  logic asp_reg, asp_next;             // slumber_not_partial_select
  logic strap_done_reg, strap_done_next; // platform flags captured once
  logic busy_prev_reg, busy_prev_next; // queue-busy history for edge
  logic [31:0] rdata_reg, rdata_next;
  logic post_reg, post_next;
  logic led_reg, led_next;
  spcs_lp_e lp_reg, lp_next;
  logic led_raw;                       // combinational led decision
  logic hit;                           // register window selected
  logic [31:0] word;                   // current register image
  logic q_busy;                        // any command outstanding

  assign hit = (ADDR == ADDR_W'(SPCS_OFF_PORT_CMD));
  assign q_busy = CMD_ISSUED_ANY | ACTIVE_QUEUE_ANY;

  // ---------------------------------------------------------------------------
  // led decision
  // ---------------------------------------------------------------------------
  spcs_led u_led (
    .cmd_active(CMD_LIST_BUSY),
    .packet_dev(pkt_reg),
    .led_on_packet(led_on_packet_device_enable_reg),
    .led_on(led_raw)
  );

  // ---------------------------------------------------------------------------
  // register image
  // ---------------------------------------------------------------------------
  // lower fields other than the enable, switch state and the two running flags belong elsewhere; read zero
  always_comb begin
    word = 32'h0000_0000;
    word[SPCS_B_FRE] = fre_reg;
    // switch state only means something on a port that has the switch
    word[SPCS_B_MPSS] = mech_switch_supported_reg & MECH_SWITCH_OPEN;
    word[SPCS_B_FR] = fr_reg;
    word[SPCS_B_CR] = cr_reg;
    word[SPCS_B_CPS] = cps_reg;
    word[SPCS_B_PMA] = pma_reg;
    word[SPCS_B_HOT_PLUG_CAPABLE] = hot_plug_capable_reg;
    word[SPCS_B_MECH_SWITCH_SUPPORTED] = mech_switch_supported_reg;
    word[SPCS_B_CPD] = cpd_reg;
    word[SPCS_B_ESP] = esp_reg;
    word[SPCS_B_PKT] = pkt_reg;
    word[SPCS_B_LED_ON_PACKET_DEVICE_ENABLE] = led_on_packet_device_enable_reg;
    word[SPCS_B_AGGRESSIVE_LINK_PM_ENABLE] = aggressive_link_pm_enable_reg;
    word[SPCS_B_ASP] = asp_reg;
  end

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    fre_next = fre_reg;
    pma_next = pma_reg;
    pkt_next = pkt_reg;
    led_on_packet_device_enable_next = led_on_packet_device_enable_reg;
    aggressive_link_pm_enable_next = aggressive_link_pm_enable_reg;
    asp_next = asp_reg;
    hot_plug_capable_next = hot_plug_capable_reg;
    mech_switch_supported_next = mech_switch_supported_reg;
    cpd_next = cpd_reg;
    esp_next = esp_reg;
    strap_done_next = 1'b1;
    // platform flags are straps, caught on the first edge after reset release
    if (!strap_done_reg) begin
      mech_switch_supported_next = PLAT_MECH_SWITCH_SUPPORTED;
      cpd_next = PLAT_COLD_PRESENCE_SUPPORTED;
      esp_next = PLAT_EXTERNAL_SIGNAL_ONLY;
      // a switch or cold presence port is always a hot plug port
      hot_plug_capable_next = PLAT_HOT_PLUG_CAPABLE | PLAT_MECH_SWITCH_SUPPORTED | PLAT_COLD_PRESENCE_SUPPORTED;
    end
    // software writes
    if (WR_EN && hit) begin
      fre_next = WDATA[SPCS_B_FRE];
      // multiplier bit only moves on a write, never from the link
      if (CAP_MULTIPLIER_SUPPORT) begin
        pma_next = WDATA[SPCS_B_PMA];
      end
      pkt_next = WDATA[SPCS_B_PKT];
      led_on_packet_device_enable_next = WDATA[SPCS_B_LED_ON_PACKET_DEVICE_ENABLE];
      // unsupported aggressive power stays zero, so it reads as reserved
      aggressive_link_pm_enable_next = WDATA[SPCS_B_AGGRESSIVE_LINK_PM_ENABLE] & CAP_AGGRESSIVE_LPM_SUPPORT;
      asp_next = WDATA[SPCS_B_ASP] & CAP_AGGRESSIVE_LPM_SUPPORT;
    end
    // receive running rises with enable, falls only after the engine is idle
    if (fre_reg) begin
      fr_next = 1'b1;
    end else if (!FIS_RX_BUSY) begin
      fr_next = 1'b0;
    end else begin
      fr_next = fr_reg;
    end
    cr_next = CMD_LIST_BUSY;
    cps_next = cpd_reg & COLD_PRESENCE_DETECT;
    // posting needs the enable, except the first register frame after init
    post_next = FIS_RX_PENDING & (fre_reg | FIS_RX_FIRST_D2H);
    led_next = led_raw;
    busy_prev_next = q_busy;
    // ---- aggressive link power: act on queue draining
    lp_next = lp_reg;
    if (q_busy) begin
      lp_next = SPCS_LP_ACTIVE;
    end else if (aggressive_link_pm_enable_reg && busy_prev_reg && LINK_IDLE) begin
      lp_next = asp_reg ? SPCS_LP_SLUMBER : SPCS_LP_PARTIAL;
    end
    rdata_next = (RD_EN && hit) ? word : 32'h0000_0000;
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fre_reg <= SPCS_RST_OTHER;
      fr_reg <= SPCS_RST_OTHER;
      cr_reg <= SPCS_RST_OTHER;
      cps_reg <= SPCS_RST_OTHER;
      pma_reg <= SPCS_RST_OTHER;
      hot_plug_capable_reg <= SPCS_RST_HOT_PLUG_CAPABLE;
      mech_switch_supported_reg <= SPCS_RST_OTHER;
      cpd_reg <= SPCS_RST_OTHER;
      esp_reg <= SPCS_RST_OTHER;
      pkt_reg <= SPCS_RST_OTHER;
      led_on_packet_device_enable_reg <= SPCS_RST_OTHER;
      aggressive_link_pm_enable_reg <= SPCS_RST_OTHER;
      asp_reg <= SPCS_RST_OTHER;
      strap_done_reg <= 1'b0;
      busy_prev_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      post_reg <= 1'b0;
      led_reg <= 1'b0;
      lp_reg <= SPCS_LP_ACTIVE;
    end else begin
      fre_reg <= fre_next;
      fr_reg <= fr_next;
      cr_reg <= cr_next;
      cps_reg <= cps_next;
      pma_reg <= pma_next;
      hot_plug_capable_reg <= hot_plug_capable_next;
      mech_switch_supported_reg <= mech_switch_supported_next;
      cpd_reg <= cpd_next;
      esp_reg <= esp_next;
      pkt_reg <= pkt_next;
      led_on_packet_device_enable_reg <= led_on_packet_device_enable_next;
      aggressive_link_pm_enable_reg <= aggressive_link_pm_enable_next;
      asp_reg <= asp_next;
      strap_done_reg <= strap_done_next;
      busy_prev_reg <= busy_prev_next;
      rdata_reg <= rdata_next;
      post_reg <= post_next;
      led_reg <= led_next;
      lp_reg <= lp_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------------------
  assign RDATA = rdata_reg;
  assign FIS_RX_POST = post_reg;
  assign ACT_LED = led_reg;
  assign LINK_PM_REQ = lp_reg;
endmodule

/* verification/spcs_properties.sv */
// pin-level assertions for the port command and status block
`timescale 1ns/1ps
module spcs_properties
  import spcs_pkg::*;
#(
  parameter int ADDR_W = 8 // register window address width
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [31:0] RDATA,
  input wire logic CAP_AGGRESSIVE_LPM_SUPPORT,
  input wire logic PLAT_MECH_SWITCH_SUPPORTED,
  input wire logic PLAT_COLD_PRESENCE_SUPPORTED,
  input wire logic FIS_RX_PENDING,
  input wire logic FIS_RX_FIRST_D2H,
  input wire logic CMD_LIST_BUSY,
  input wire logic CMD_ISSUED_ANY,
  input wire logic ACTIVE_QUEUE_ANY,
  input wire logic FIS_RX_POST,
  input wire logic ACT_LED,
  input wire logic [1:0] LINK_PM_REQ
);
  // ---------------------------------------------------------------------------
  // one clock domain, async reset gates everything
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire logic hit = RD_EN && (ADDR == ADDR_W'(SPCS_OFF_PORT_CMD)); // read of our word
  wire logic q_busy = CMD_ISSUED_ANY | ACTIVE_QUEUE_ANY; // queue not empty
  a_unmapped_zero: assert property (RD_EN && !hit |=> RDATA == 32'h0) else $error("unmapped read not zero");
  a_hot_plug_capable_forced: assert property (hit && (PLAT_MECH_SWITCH_SUPPORTED | PLAT_COLD_PRESENCE_SUPPORTED)
    |=> RDATA[18]) else $error("hot plug flag low with switch or cold presence");
  a_lpm_nocap: assert property (hit && !CAP_AGGRESSIVE_LPM_SUPPORT |=> RDATA[27:26] == 2'h0)
    else $error("link power bits set without capability");
  a_pm_busy: assert property (q_busy |=> LINK_PM_REQ == 2'h0) else $error("low power asked while busy");
  a_pm_held: assert property (LINK_PM_REQ != 2'h0 && !q_busy && !WR_EN |=> $stable(LINK_PM_REQ))
    else $error("low power request dropped while idle");
  a_led_idle: assert property (!CMD_LIST_BUSY |=> !ACT_LED) else $error("led lit with no commands");
  a_rx_first: assert property (FIS_RX_PENDING && FIS_RX_FIRST_D2H |=> FIS_RX_POST)
    else $error("first register frame not posted");
  a_rx_none: assert property (!FIS_RX_PENDING |=> !FIS_RX_POST) else $error("post with nothing pending");
endmodule
bind spcs_top spcs_properties #(.ADDR_W(ADDR_W)) u_spcs_properties (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .CAP_AGGRESSIVE_LPM_SUPPORT(CAP_AGGRESSIVE_LPM_SUPPORT),
  .PLAT_MECH_SWITCH_SUPPORTED(PLAT_MECH_SWITCH_SUPPORTED), .PLAT_COLD_PRESENCE_SUPPORTED(PLAT_COLD_PRESENCE_SUPPORTED),
  .FIS_RX_PENDING(FIS_RX_PENDING), .FIS_RX_FIRST_D2H(FIS_RX_FIRST_D2H), .CMD_LIST_BUSY(CMD_LIST_BUSY),
  .CMD_ISSUED_ANY(CMD_ISSUED_ANY), .ACTIVE_QUEUE_ANY(ACTIVE_QUEUE_ANY), .FIS_RX_POST(FIS_RX_POST),
  .ACT_LED(ACT_LED), .LINK_PM_REQ(LINK_PM_REQ));

/* verification/sata_port_cmd_status_upper_test.sv */
// self-checking bench for the port command and status block
`timescale 1ns/1ps
module sata_port_cmd_status_upper_test;
  import spcs_pkg::*;
  logic clk, nrst, wr_en, rd_en, cap_mult, cap_agg, cpd_det, rx_busy, rx_pend, rx_first, cmd_busy, ci, aq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic rx_post, act_led;
  logic sw_open; // mechanical presence switch level
  logic [1:0] pm_req;
  int failures = 0; // mismatches seen
  int checks_done = 0; // comparisons made
  spcs_top u_spcs_top (.CLK(clk), .NRST(nrst), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata),
    .RDATA(rdata), .CAP_MULTIPLIER_SUPPORT(cap_mult), .CAP_AGGRESSIVE_LPM_SUPPORT(cap_agg),
    .PLAT_HOT_PLUG_CAPABLE(1'b0), .PLAT_MECH_SWITCH_SUPPORTED(1'b1), .PLAT_COLD_PRESENCE_SUPPORTED(1'b1),
    .PLAT_EXTERNAL_SIGNAL_ONLY(1'b0), .COLD_PRESENCE_DETECT(cpd_det), .MECH_SWITCH_OPEN(sw_open),
    .FIS_RX_BUSY(rx_busy), .FIS_RX_PENDING(rx_pend), .FIS_RX_FIRST_D2H(rx_first), .CMD_LIST_BUSY(cmd_busy),
    .CMD_ISSUED_ANY(ci), .ACTIVE_QUEUE_ANY(aq), .LINK_IDLE(1'b1), .FIS_RX_POST(rx_post), .ACT_LED(act_led),
    .LINK_PM_REQ(pm_req));
  // ---------------------------------------------------------------------------
  // clock, checking and bus helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // strobes are one-cycle pulses launched at the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr = a;
    rd_en = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    chk(rdata, e);
  endtask
  task automatic conclude;
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // multiplier and link power bits are gated by capabilities, unmapped space is inert
  task automatic t_access;
    rd(8'h18, 32'h001C0000);
    wr(8'h18, 32'hFFFFFFFF);
    cyc(2);
    rd(8'h18, 32'h031C4010);
    cap_mult = 1'b1;
    cap_agg = 1'b1;
    wr(8'h18, 32'hFFFFFFFF);
    cyc(2);
    rd(8'h18, 32'h0F1E4010);
    wr(8'h1C, 32'h0);
    rd(8'h1C, 32'h0);
    // let an edge pass so the read strobe is not driven twice in one step
    cyc(1);
    rd(8'h18, 32'h0F1E4010);
    // an open switch shows in the lower state bit on a switch-equipped port
    sw_open = 1'b1;
    cyc(1);
    rd(8'h18, 32'h0F1E6010);
    sw_open = 1'b0;
  endtask
  // running flag waits for the engine to go idle after enable drops
  task automatic t_rx;
    rx_busy = 1'b1;
    wr(8'h18, 32'h0F020000);
    cyc(2);
    rd(8'h18, 32'h0F1E4000);
    rx_busy = 1'b0;
    cyc(2);
    rd(8'h18, 32'h0F1E0000);
    rx_pend = 1'b1;
    cyc(2);
    chk(rx_post, 1'b0);
    rx_first = 1'b1;
    cyc(2);
    chk(rx_post, 1'b1);
    rx_first = 1'b0;
    wr(8'h18, 32'h0F020010);
    cyc(2);
    chk(rx_post, 1'b1);
    rx_pend = 1'b0;
  endtask
  // engine and presence status, then every led mode combination
  task automatic t_led;
    cmd_busy = 1'b1;
    cpd_det = 1'b1;
    cyc(2);
    rd(8'h18, 32'h0F1FC010);
    for (int i = 0; i < 4; i++) begin
      wr(8'h18, 32'h0C000010 | (i << 24));
      cyc(2);
      chk(act_led, i[0] ? i[1] : 1'b1);
    end
    cmd_busy = 1'b0;
    cyc(2);
    chk(act_led, 1'b0);
  endtask
  // queue drains into partial, then slumber
  task automatic t_pm;
    for (int s = 0; s < 2; s++) begin
      wr(8'h18, 32'h04000000 | (s << 27));
      ci = ~s[0];
      aq = s[0];
      cyc(2);
      chk(pm_req, SPCS_LP_ACTIVE);
      ci = 1'b0;
      aq = 1'b0;
      cyc(3);
      chk(pm_req, s ? SPCS_LP_SLUMBER : SPCS_LP_PARTIAL);
    end
  endtask
  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    {nrst, wr_en, rd_en, cap_mult, cap_agg, cpd_det, rx_busy, rx_pend, rx_first, cmd_busy, ci, aq} = 12'h0;
    addr = 8'h0;
    sw_open = 1'b0;
    wdata = 32'h0;
    cyc(8);
    nrst = 1'b1;
    cyc(2);
    t_access();
    t_rx();
    t_led();
    t_pm();
    conclude();
  end
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule
